//--- high_port_gpio_bank.sv
// Upper-port GPIO bank: latches, output modes, read-back and memory takeover
`timescale 1ns/10ps
module high_port_gpio_bank
    import high_port_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        ce,
    // Special-function register access
    input  wire logic [7:0]  sfr_addr,
    input  wire logic        sfr_wr,
    input  wire logic [7:0]  sfr_wdata,
    input  wire logic        sfr_rd,
    input  wire logic        sfr_rmw,
    output logic      [7:0]  sfr_rdata,
    output logic             sfr_hit,
    // Loose crossbar bits
    input  wire logic        pullup_global_disable,
    input  wire logic        memif_high_en,
    // Memory interface during an off-chip move
    input  wire logic        memif_active,
    input  wire logic        memif_read,
    input  wire logic        memif_mux_mode,
    input  wire logic        memif_wr_n,
    input  wire logic        memif_rd_n,
    input  wire logic        memif_ale,
    input  wire logic [7:0]  memif_port_b,
    input  wire logic [7:0]  memif_port_c,
    input  wire logic [7:0]  memif_port_d,
    // Pins, port a in bits 7..0 up to port d in bits 31..24
    input  wire logic [31:0] pin_in,
    output logic      [31:0] pin_out,
    output logic      [31:0] pin_oe,
    output logic      [31:0] pullup_en
);

    // Output latches, one byte per port
    logic [7:0]  latch_reg [PORT_COUNT];
    logic [7:0]  latch_next [PORT_COUNT];
    // Output-mode register, one bit per nibble
    logic [7:0]  high_ports_output_mode_reg;
    logic [7:0]  high_ports_output_mode_next;
    // Read data and hit flag toward the core
    logic [7:0]  rdata_reg;
    logic [7:0]  rdata_next;
    logic        hit_reg;
    logic        hit_next;
    // Registered pin drive
    logic [31:0] pin_out_reg;
    logic [31:0] pin_oe_reg;
    logic [31:0] pullup_en_reg;
    // Combinational pin drive from the cells
    logic [31:0] drive_val;
    logic [31:0] drive_en;
    logic [31:0] drive_pu;
    // Takeover terms
    logic        takeover;
    logic [31:0] ovr_en;
    logic [31:0] ovr_val;
    logic [31:0] latch_flat;
    logic [31:0] pp_mask;
    // Port index decode
    logic        port_sel;
    logic [1:0]  port_idx;

    assign port_sel = (sfr_addr >= PORT_A_OFFSET) && (sfr_addr <= PORT_D_OFFSET);
    assign port_idx = 2'(sfr_addr - PORT_A_OFFSET);

    // Register write path
    always_comb
    begin
        for (int p = 0; p < PORT_COUNT; p++)
        begin
            latch_next[p] = latch_reg[p];
        end
        high_ports_output_mode_next = high_ports_output_mode_reg;
        if (sfr_wr)
        begin
            // Latches stay writable even on parts with no pins bonded
            if (port_sel)
            begin
                latch_next[port_idx] = sfr_wdata;
            end
            else if (sfr_addr == OUT_MODE_OFFSET)
            begin
                high_ports_output_mode_next = sfr_wdata;
            end
        end
    end

    // Register read path; a read never disturbs the latches or the mode register
    always_comb
    begin
        rdata_next = rdata_reg;
        hit_next   = 1'b0;
        if (sfr_rd)
        begin
            hit_next = 1'b1;
            if (port_sel)
            begin
                // The modify phase must see what was written, not the wire
                if (sfr_rmw)
                begin
                    rdata_next = latch_reg[port_idx];
                end
                else
                begin
                    rdata_next = pin_in[port_idx*8 +: 8];
                end
            end
            else if (sfr_addr == OUT_MODE_OFFSET)
            begin
                rdata_next = high_ports_output_mode_reg;
            end
            else
            begin
                // Not ours: answer zero and drop the hit flag
                rdata_next = UNMAPPED_READ;
                hit_next   = 1'b0;
            end
        end
    end

    // Register state; clock enable freezes everything
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            for (int p = 0; p < PORT_COUNT; p++)
            begin
                latch_reg[p] <= LATCH_RESET;
            end
            high_ports_output_mode_reg <= OUT_MODE_RESET;
            rdata_reg                  <= UNMAPPED_READ;
            hit_reg                    <= 1'b0;
        end
        else if (ce)
        begin
            for (int p = 0; p < PORT_COUNT; p++)
            begin
                latch_reg[p] <= latch_next[p];
            end
            high_ports_output_mode_reg <= high_ports_output_mode_next;
            rdata_reg                  <= rdata_next;
            hit_reg                    <= hit_next;
        end
    end

    // Memory interface takeover map
    always_comb
    begin
        takeover = memif_high_en & memif_active;
        ovr_en   = '0;
        ovr_val  = '0;
        if (takeover)
        begin
            // Port a upper bits carry the strobes
            ovr_en[WR_STROBE_BIT]  = 1'b1;
            ovr_val[WR_STROBE_BIT] = memif_wr_n;
            ovr_en[RD_STROBE_BIT]  = 1'b1;
            ovr_val[RD_STROBE_BIT] = memif_rd_n;
            ovr_en[ALE_BIT]        = 1'b1;
            ovr_val[ALE_BIT]       = memif_ale;
            // Port b only holds upper address when not multiplexed
            ovr_en[15:8]           = memif_mux_mode ? 8'h00 : 8'hFF;
            ovr_val[15:8]          = memif_port_b;
            ovr_en[23:16]          = 8'hFF;
            ovr_val[23:16]         = memif_port_c;
            ovr_en[31:24]          = 8'hFF;
            ovr_val[31:24]         = memif_port_d;
        end
    end

    // Flatten latches and expand mode bits over nibbles
    always_comb
    begin
        for (int p = 0; p < PORT_COUNT; p++)
        begin
            latch_flat[p*8 +: 8] = latch_reg[p];
        end
        for (int n = 0; n < NIBBLE_COUNT; n++)
        begin
            pp_mask[n*4 +: 4] = {4{high_ports_output_mode_reg[n]}};
        end
    end

    // One drive cell per nibble; bit n of the mode register steers nibble n
    for (genvar n = 0; n < NIBBLE_COUNT; n++)
    begin : g_nib
        // Data bus lives on port d; an off-chip read must float it
        localparam bit IS_DATA = (n >= 6);
        nibble_drive_cell #(
            .WIDTH (4)
        ) u_cell (
            .push_pull (high_ports_output_mode_reg[n]),
            .latch_val (latch_flat[n*4 +: 4]),
            .ovr_en    (ovr_en[n*4 +: 4]),
            .ovr_val   (ovr_val[n*4 +: 4]),
            .drv_off   (IS_DATA & takeover & memif_read),
            .pu_dis    (pullup_global_disable),
            .pin_val   (drive_val[n*4 +: 4]),
            .pin_en    (drive_en[n*4 +: 4]),
            .pu_en     (drive_pu[n*4 +: 4])
        );
    end

    // Pin outputs leave from flops; pull-ups come up enabled
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pin_out_reg   <= '1;
            pin_oe_reg    <= '0;
            pullup_en_reg <= '1;
        end
        else if (ce)
        begin
            pin_out_reg   <= drive_val;
            pin_oe_reg    <= drive_en;
            pullup_en_reg <= drive_pu;
        end
    end

    assign sfr_rdata = rdata_reg;
    assign sfr_hit   = hit_reg;
    assign pin_out   = pin_out_reg;
    assign pin_oe    = pin_oe_reg;
    assign pullup_en = pullup_en_reg;

    // Checks on the bank's behaviour
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    pin_read_a: assert property (
        ce && sfr_rd && !sfr_rmw && sfr_addr == PORT_A_OFFSET
        |=> sfr_rdata == $past(pin_in[7:0]))
        else $error("port read did not return pin levels");

    rmw_latch_a: assert property (
        ce && sfr_rd && sfr_rmw && sfr_addr == PORT_B_OFFSET
        |=> sfr_rdata == $past(latch_reg[1]))
        else $error("rmw read did not return latch");

    pp_drive_a: assert property (
        ce && !takeover && high_ports_output_mode_reg[0]
        |=> pin_oe[3:0] == 4'hF && pin_out[3:0] == $past(latch_reg[0][3:0]))
        else $error("push-pull nibble not driven both ways");

    od_release_a: assert property (
        ce && !takeover && !high_ports_output_mode_reg[2]
        |=> pin_oe[11:8] == ~$past(latch_reg[1][3:0]))
        else $error("open-drain nibble drive wrong");

    nibble_map_a: assert property (
        ce && !takeover && high_ports_output_mode_reg[7:6] == 2'b10
        && latch_reg[3][3:0] == 4'hF
        |=> pin_oe[31:24] == 8'hF0)
        else $error("mode bit did not steer its own nibble");

    pullup_off_a: assert property (
        ce && pullup_global_disable |=> pullup_en == 32'h0000_0000)
        else $error("global disable left a pull-up on");

    no_fight_a: assert property (
        (pullup_en & pin_oe & ~pin_out) == 32'h0000_0000)
        else $error("pull-up on while pin driven low");

    strobe_ovr_a: assert property (
        ce && memif_high_en && memif_active
        |=> pin_out[7] == $past(memif_wr_n) && pin_out[6] == $past(memif_rd_n)
            && pin_out[5] == $past(memif_ale))
        else $error("strobes not on port a");

    bus_ovr_a: assert property (
        ce && memif_high_en && memif_active
        |=> pin_out[23:16] == $past(memif_port_c))
        else $error("memory interface did not override port c");

    rd_float_a: assert property (
        ce && memif_high_en && memif_active && memif_read
        |=> pin_oe[31:24] == 8'h00)
        else $error("data bus driven during off-chip read");

    drive_rule_a: assert property (
        ce && !(memif_high_en && memif_active && memif_read)
        |=> pin_oe == ($past(pp_mask) | ~pin_out))
        else $error("driver enable does not follow mode and value");

    latch_wr_a: assert property (
        ce && sfr_wr && sfr_addr == PORT_D_OFFSET
        ##1 ce && sfr_rd && sfr_rmw && sfr_addr == PORT_D_OFFSET
        |=> sfr_rdata == $past(sfr_wdata, 2))
        else $error("latch write not read back");

    takeover_c: cover property (ce && memif_high_en && memif_active && memif_read);
    rmw_c:      cover property (ce && sfr_rd && sfr_rmw && port_sel);
    mode_wr_c:  cover property (ce && sfr_wr && sfr_addr == OUT_MODE_OFFSET
                                && sfr_wdata == 8'hFF);

endmodule : high_port_gpio_bank

//--- high_port_pkg.sv
// Constants and offsets for the upper-port GPIO bank
// Behaviour
// - Normal port read returns sampled pin levels
// - Read-modify-write read returns stored latch
// - Push-pull drives latch value both ways
// - Open-drain drives low, releases on one
// - One mode bit governs four pins
// - Mode bits map port d high downward
// - Pull-ups on by default, global disable
// - Pull-up off on pins driven low
// - Memory interface overrides outputs while moving
// - Off-chip read disables data bus drivers
// - Unpinned port registers remain fully usable
// - Latches reset high, writes reach pins
// - Port a bits 7..5 carry strobes
package high_port_pkg;
    // Register offsets on the special-function bus
    localparam logic [7:0] PORT_A_OFFSET   = 8'h84;
    localparam logic [7:0] PORT_B_OFFSET   = 8'h85;
    localparam logic [7:0] PORT_C_OFFSET   = 8'h86;
    localparam logic [7:0] PORT_D_OFFSET   = 8'h87;
    localparam logic [7:0] OUT_MODE_OFFSET = 8'hB5;
    // Values after reset
    localparam logic [7:0] LATCH_RESET     = 8'hFF;
    localparam logic [7:0] OUT_MODE_RESET  = 8'h00;
    localparam logic [7:0] UNMAPPED_READ   = 8'h00;
    // Port a pins taken by the memory interface strobes
    localparam int         WR_STROBE_BIT   = 7;
    localparam int         RD_STROBE_BIT   = 6;
    localparam int         ALE_BIT         = 5;
    // Geometry
    localparam int         PORT_COUNT      = 4;
    localparam int         NIBBLE_COUNT    = 8;
    localparam int         PIN_COUNT       = 32;
endpackage : high_port_pkg

//--- nibble_drive_cell.sv
// Output drive, enable and pull-up logic for one group of four pins
`timescale 1ns/10ps
module nibble_drive_cell
    import high_port_pkg::*;
#(
    parameter int WIDTH = 4
)
(
    input  wire logic             push_pull,
    input  wire logic [WIDTH-1:0] latch_val,
    input  wire logic [WIDTH-1:0] ovr_en,
    input  wire logic [WIDTH-1:0] ovr_val,
    input  wire logic             drv_off,
    input  wire logic             pu_dis,
    output logic      [WIDTH-1:0] pin_val,
    output logic      [WIDTH-1:0] pin_en,
    output logic      [WIDTH-1:0] pu_en
);
    // Per-pin drive decision; the whole group shares one mode bit
    always_comb
    begin
        for (int i = 0; i < WIDTH; i++)
        begin
            // Memory interface wins over the latch while it owns the pin
            pin_val[i] = ovr_en[i] ? ovr_val[i] : latch_val[i];
            // Drive when push-pull or when low; otherwise float
            pin_en[i]  = (push_pull | ~pin_val[i]) & ~drv_off;
            // Pull-up never fights a driven low
            pu_en[i]   = ~pu_dis & ~(pin_en[i] & ~pin_val[i]);
        end
    end
endmodule : nibble_drive_cell

//--- ext_pin_model.sv
// Model of the devices and wiring that share the upper-port pins
`timescale 1ns/10ps
module ext_pin_model
(
    input  wire logic        clk,
    input  wire logic [31:0] pin_out,
    input  wire logic [31:0] pin_oe,
    input  wire logic [31:0] pullup_en,
    input  wire logic [31:0] ext_en,
    input  wire logic [31:0] ext_val,
    output logic      [31:0] pin_in
);
    logic [31:0] float_pat = 32'h5555AAAA; // Undriven pins wander, so no check can lean on them
    // Floating level changes every cycle
    always @(posedge clk) float_pat <= ~float_pat;
    // Wire level: block driver, then outside driver, then the weak pull-up
    always_comb
    begin
        for (int i = 0; i < 32; i++)
        begin
            if (pin_oe[i])
                pin_in[i] = pin_out[i];
            else if (ext_en[i])
                pin_in[i] = ext_val[i];
            else if (pullup_en[i])
                pin_in[i] = 1'b1;
            else
                pin_in[i] = float_pat[i];
        end
    end
endmodule : ext_pin_model

//--- high_port_gpio_bank_tb_top.sv
// Self-checking testbench for the upper-port GPIO bank
`timescale 1ns/10ps
module high_port_gpio_bank_tb_top;
    import high_port_pkg::*;
    logic        clk, nrst, ce, sfr_wr, sfr_rd, sfr_rmw, sfr_hit;
    logic        pullup_global_disable, memif_high_en, memif_active, memif_read;
    logic        memif_mux_mode, memif_wr_n, memif_rd_n, memif_ale;
    logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, memif_port_b, memif_port_c, memif_port_d;
    logic [31:0] pin_in, pin_out, pin_oe, pullup_en, ext_en, ext_val;
    int          err_count, checks_done;
    logic [7:0]  rdat; // Last read data
    logic        rhit; // Last read hit flag
    logic [31:0] eoe;  // Expected enables
    high_port_gpio_bank uut (.clk, .nrst, .ce, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rd,
        .sfr_rmw, .sfr_rdata, .sfr_hit, .pullup_global_disable, .memif_high_en,
        .memif_active, .memif_read, .memif_mux_mode, .memif_wr_n, .memif_rd_n, .memif_ale,
        .memif_port_b, .memif_port_c, .memif_port_d, .pin_in, .pin_out, .pin_oe, .pullup_en);
    ext_pin_model pins (.clk, .pin_out, .pin_oe, .pullup_en, .ext_en, .ext_val, .pin_in);
    // 200 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // Compare and count
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk
    // One register write, taken at the second edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        sfr_addr  <= a;
        sfr_wdata <= d;
        sfr_wr    <= 1'b1;
        @(posedge clk);
        sfr_wr    <= 1'b0;
    endtask : wr
    // One register read; data and hit are settled just after the taking edge
    task automatic rd(input logic [7:0] a, input logic m);
        @(posedge clk);
        sfr_addr <= a;
        sfr_rmw  <= m;
        sfr_rd   <= 1'b1;
        @(posedge clk);
        sfr_rd   <= 1'b0;
        #1;
        rdat = sfr_rdata;
        rhit = sfr_hit;
    endtask : rd
    // Pins are registered, so give inputs time to reach them
    task automatic settle;
        repeat (3) @(posedge clk);
        #1;
    endtask : settle
    // Pin reads, latch reads and unmapped reads
    task automatic t_readback;
        ext_en  <= 32'h000000FF;
        ext_val <= 32'h0000005A;
        settle();
        rd(PORT_A_OFFSET, 1'b0);
        chk("pin read", 8'h5A, rdat);
        rd(PORT_A_OFFSET, 1'b1);
        chk("latch read", 8'hFF, rdat);
        ext_en <= 32'h0;
        for (int p = 0; p < 4; p++)
        begin
            wr(PORT_A_OFFSET + p[7:0], 8'hC3 ^ p[7:0]);
            rd(PORT_A_OFFSET + p[7:0], 1'b1);
            chk("latch back", 8'hC3 ^ p[7:0], rdat);
        end
        rd(8'h88, 1'b0);
        chk("unmapped", 9'h000, {rhit, rdat});
    endtask : t_readback
    // Every mode bit alone, latches 0F so each low nibble shows its mode; high nibbles drive low in either mode
    task automatic t_modes;
        for (int p = 0; p < 4; p++)
            wr(PORT_A_OFFSET + p[7:0], 8'h0F);
        for (int i = 0; i < 8; i++)
        begin
            wr(OUT_MODE_OFFSET, 8'h01 << i);
            settle();
            for (int n = 0; n < 8; n++)
                eoe[4*n +: 4] = (n == i || n % 2 == 1) ? 4'hF : 4'h0;
            chk("pin out", 32'h0F0F0F0F, pin_out);
            chk("pin oe", eoe, pin_oe);
            chk("pullup", ~(eoe & 32'hF0F0F0F0), pullup_en);
            rd(OUT_MODE_OFFSET, 1'b0);
            chk("mode read", {1'b1, 8'h01 << i}, {rhit, rdat});
        end
        // Inputs only move on a rising edge
        @(posedge clk);
        pullup_global_disable <= 1'b1;
        settle();
        chk("pullup off", 32'h0, pullup_en);
        @(posedge clk);
        pullup_global_disable <= 1'b0;
    endtask : t_modes
    // Memory interface takeover, read float, and hand-back
    task automatic t_takeover;
        wr(OUT_MODE_OFFSET, 8'hFF);
        memif_high_en <= 1'b1;
        memif_active  <= 1'b1;
        settle();
        chk("memif out", 32'h963CA56F, pin_out);
        chk("memif oe", 32'hFFFFFFFF, pin_oe);
        @(posedge clk);
        memif_read     <= 1'b1;
        memif_mux_mode <= 1'b1;
        settle();
        chk("read oe", 32'h00FFFFFF, pin_oe);
        chk("mux port b", 8'h0F, pin_out[15:8]);
        rd(OUT_MODE_OFFSET, 1'b0);
        chk("mode kept", 8'hFF, rdat);
        @(posedge clk);
        memif_active <= 1'b0;
        memif_read   <= 1'b0;
        settle();
        chk("hand back", 32'h0F0F0F0F, pin_out);
    endtask : t_takeover
    // Clock enable low: a write and a pull-up change are both ignored
    task automatic t_freeze;
        @(posedge clk);
        ce                    <= 1'b0;
        pullup_global_disable <= 1'b1;
        wr(PORT_A_OFFSET, 8'h00);
        settle();
        chk("frozen pullup", 32'h0F0F0F0F, pullup_en);
        chk("frozen pins", 32'h0F0F0F0F, pin_out);
        @(posedge clk);
        ce                    <= 1'b1;
        pullup_global_disable <= 1'b0;
        rd(PORT_A_OFFSET, 1'b1);
        chk("frozen latch", 8'h0F, rdat);
    endtask : t_freeze
    // Write, then a read-modify-write read in the very next cycle
    task automatic t_back_to_back;
        @(posedge clk);
        sfr_addr  <= PORT_D_OFFSET;
        sfr_wdata <= 8'h3C;
        sfr_wr    <= 1'b1;
        @(posedge clk);
        sfr_wr    <= 1'b0;
        sfr_rmw   <= 1'b1;
        sfr_rd    <= 1'b1;
        @(posedge clk);
        sfr_rd    <= 1'b0;
        #1;
        chk("next-cycle read", 8'h3C, sfr_rdata);
    endtask : t_back_to_back
    // Counts and verdict
    task automatic final_report;
        $display("checks %0d, mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : final_report
    // Main sequence
    initial
    begin
        {nrst, sfr_wr, sfr_rd, sfr_rmw, pullup_global_disable, memif_high_en} = '0;
        {memif_active, memif_read, memif_mux_mode, memif_wr_n} = '0;
        {memif_rd_n, memif_ale, ce} = 3'b111;
        {sfr_addr, sfr_wdata} = '0;
        {memif_port_b, memif_port_c, memif_port_d} = 24'hA53C96;
        {ext_en, ext_val} = '0;
        err_count = 0;
        checks_done = 0;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        #1;
        chk("reset out", LATCH_RESET * 32'h01010101, pin_out);
        chk("reset oe", 32'h0, pin_oe);
        chk("reset pullup", 32'hFFFFFFFF, pullup_en);
        t_readback();
        t_modes();
        t_takeover();
        t_freeze();
        t_back_to_back();
        final_report();
    end
    // Hang guard, far beyond the roughly 130 cycles the tests need
    initial
    begin
        #20us;
        err_count++;
        final_report();
    end
endmodule : high_port_gpio_bank_tb_top
